// *** mph_regs.svh ***
`ifndef MPH_REGS_SVH
`define MPH_REGS_SVH
// register byte offsets on the control bus
`define MPH_CTRL_OFS 8'h00
`define MPH_STRAPS_OFS 8'h04
`define MPH_STATUS_OFS 8'h08
`define MPH_ADDR_OFS 8'h0C
// reset values
`define MPH_CTRL_RESET 32'h00000001
`define MPH_UPPER_RESET 11'h000
// control register fields
`define MPH_CTRL_ENABLE 0
// strap positions
`define MPH_STRAP_BUSSEL_HI 3
`define MPH_STRAP_BUSSEL_LO 1
`define MPH_STRAP_ORDER 4
`define MPH_STRAP_POL 5
`define MPH_STRAP_ALT 11
`define MPH_STRAP_HALVE 12
`define MPH_STRAP_DRIVE 15
`define MPH_BUSSEL_MUX 3'h7
// address layout
`define MPH_REGION_BIT 23
`define MPH_ALIAS_HI 20
// axi responses
`define MPH_RESP_OKAY 2'h0
`define MPH_RESP_SLVERR 2'h2
// synchroniser width: nine control pins, 13 address, 16 data, 16 straps
`define MPH_SYNC_W 54
`endif

// *** mph_pkg.sv ***
package mph_pkg;
  // host access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_ALIGN, ST_DONE} mph_state_type;
  // target region of an access
  typedef enum logic {REGION_REG, REGION_BUF} mph_region_type;
endpackage

// *** mph_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for a bundle of pins
module mph_sync
#(
  parameter int W = 1
)
(
  input wire logic aclk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // first stage, read only by the second
  logic [W-1:0] meta_q;

  // no reset: straps must already be valid when reset lifts
  always_ff @(posedge aclk)
  begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule
`default_nettype wire

// *** mph_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// host clock edge detect with optional halving
module mph_clk_div
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_lvl,
  input wire logic halve,
  output logic tick
);
  // previous level and halving phase
  logic lvl_q;
  logic phase_q;
  wire logic rise;

  assign rise = clk_lvl && !lvl_q;

  // edge history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lvl_q <= 1'b0;
    else
      lvl_q <= clk_lvl;
  end

  // phase toggles per host edge when halving
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_q <= 1'b0;
    else if (!halve)
      phase_q <= 1'b0;
    else if (rise)
      phase_q <= !phase_q;
  end

  // one pulse per divided host clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick <= 1'b0;
    else
      tick <= rise && (!halve || phase_q);
  end
endmodule
`default_nettype wire

// *** mph_port.sv ***
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mph_regs.svh"
// Functional notes
// - port latches upper address bits internally
// - halving strap divides host clock by two
// - host control pins are synchronised internally
// - all sixteen straps captured at reset release
// - straps 111 plus alternate select this port
// - alternate strap picks alternate interface set
// - polarity strap sets wait asserting level
// - drive strap: wait always driven, else driven only while selected
// - attribute and io accesses both answered
// - low half registers, high half buffer, aliased
// - upper strobe falling edge marks upper bits
// - io read or general read starts read
// - io write or low write starts write
// - wait held until data ready or accepted
module mph_port
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic host_port_clock,
  input wire logic upper_addr_strobe_in,
  input wire logic card_space_n,
  input wire logic io_read_strobe_in,
  input wire logic io_write_strobe_in,
  input wire logic read_strobe_n,
  input wire logic write_strobe_low_n,
  input wire logic byte_en_high_n,
  input wire logic byte_en_low_n,
  input wire logic [12:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic wait_out,
  output logic wait_oe,
  input wire logic [15:0] config_straps_in,
  output logic [15:0] config_straps,
  output logic alt_interface_sel,
  output logic port_active,
  output logic mem_req,
  output logic mem_write,
  output var mph_pkg::mph_region_type mem_region,
  output logic [20:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_byte_en,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  import mph_pkg::*;

  // swap byte lanes for big endian hosts
  function automatic logic [15:0] order_bytes(input logic [15:0] d, input logic little);
    order_bytes = little ? d : {d[7:0], d[15:8]};
  endfunction

  // true for an offset inside the register block
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[7:4] == 4'h0);
  endfunction

  // raw pin bundle and its synchronised copy
  wire logic [`MPH_SYNC_W-1:0] raw_bus;
  logic [`MPH_SYNC_W-1:0] s_bus;
  // synchronised pins
  wire logic s_hclk, s_ale, s_space_n, s_iord_n, s_iowr_n;
  wire logic s_rd_n, s_we0_n, s_be_hi_n, s_be_lo_n;
  wire logic [12:0] s_addr;
  wire logic [15:0] s_data;
  wire logic [15:0] s_straps;

  assign raw_bus = {host_port_clock, upper_addr_strobe_in, card_space_n, io_read_strobe_in,
                    io_write_strobe_in, read_strobe_n, write_strobe_low_n, byte_en_high_n,
                    byte_en_low_n, addr_in, data_in, config_straps_in};
  assign {s_hclk, s_ale, s_space_n, s_iord_n, s_iowr_n, s_rd_n, s_we0_n, s_be_hi_n,
          s_be_lo_n, s_addr, s_data, s_straps} = s_bus;

  // every host pin passes two flops
  mph_sync #(.W(`MPH_SYNC_W)) u_sync
  (
    .aclk(aclk),
    .d(raw_bus),
    .q(s_bus)
  );

  // captured straps and capture done flag
  logic [15:0] cfg_q;
  logic cfg_valid_q;

  // straps taken on first edge after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= 16'h0000;
      cfg_valid_q <= 1'b0;
    end
    else if (!cfg_valid_q)
    begin
      cfg_q <= s_straps;
      cfg_valid_q <= 1'b1;
    end
  end

  // configuration decode
  wire logic little_end, hold_pol, hold_drive, halve, port_ok;
  assign little_end = cfg_q[`MPH_STRAP_ORDER];
  assign hold_pol = cfg_q[`MPH_STRAP_POL];
  assign hold_drive = cfg_q[`MPH_STRAP_DRIVE];
  assign halve = cfg_q[`MPH_STRAP_HALVE];
  assign port_ok = cfg_valid_q && cfg_q[`MPH_STRAP_ALT]
                   && (cfg_q[`MPH_STRAP_BUSSEL_HI:`MPH_STRAP_BUSSEL_LO] == `MPH_BUSSEL_MUX);

  // host clock tick, halved by strap
  logic host_tick;
  mph_clk_div u_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_lvl(s_hclk),
    .halve(halve),
    .tick(host_tick)
  );

  // upper address latch and strobe history
  logic ale_q;
  logic [10:0] upper_q;
  wire logic ale_fall;
  assign ale_fall = ale_q && !s_ale;

  // latch upper bits on strobe falling edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ale_q <= 1'b0;
      upper_q <= `MPH_UPPER_RESET;
    end
    else
    begin
      ale_q <= s_ale;
      if (ale_fall)
        upper_q <= s_addr[10:0];
    end
  end

  // software enable from control register
  logic [31:0] ctrl_q;
  // access decode
  wire logic [23:0] full_addr;
  wire logic rd_req, wr_req, sel_win, start;
  assign full_addr = {upper_q, s_addr};
  assign rd_req = !s_iord_n || !s_rd_n;
  assign wr_req = !s_iowr_n || !s_we0_n;
  // attribute and io space share one select, no io mode needed
  assign sel_win = port_ok && !s_space_n && ctrl_q[`MPH_CTRL_ENABLE];
  assign start = sel_win && (rd_req || wr_req);

  // sequencer state
  mph_state_type state_q, state_d;
  logic is_read_q;
  logic busy_d;

  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_REQ;
      ST_REQ: if (mem_ack) state_d = ST_ALIGN;
      ST_ALIGN: if (host_tick) state_d = ST_DONE;
      ST_DONE: if (!rd_req && !wr_req) state_d = ST_IDLE;
    endcase
  end

  // wait held through request and clock alignment
  assign busy_d = (state_q == ST_IDLE && start) || state_q == ST_REQ || state_q == ST_ALIGN;

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // internal request toward registers and buffer
  logic [23:0] last_addr_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_region <= REGION_REG;
      mem_addr <= 21'h000000;
      mem_wdata <= 16'h0000;
      mem_byte_en <= 2'h0;
      last_addr_q <= 24'h000000;
      is_read_q <= 1'b0;
    end
    else if (state_q == ST_IDLE && start)
    begin
      mem_req <= 1'b1;
      mem_write <= !rd_req;
      is_read_q <= rd_req;
      // top bit picks region; bits above alias range ignored
      mem_region <= full_addr[`MPH_REGION_BIT] ? REGION_BUF : REGION_REG;
      mem_addr <= full_addr[`MPH_ALIAS_HI:0];
      mem_wdata <= order_bytes(s_data, little_end);
      mem_byte_en <= {!s_be_hi_n, !s_be_lo_n};
      last_addr_q <= full_addr;
    end
    else if (state_q == ST_REQ && mem_ack)
      mem_req <= 1'b0;
  end

  // read data onto host bus until strobes drop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_out <= 16'h0000;
      data_oe <= 1'b0;
    end
    else if (state_q == ST_REQ && mem_ack && is_read_q)
    begin
      data_out <= order_bytes(mem_rdata, little_end);
      data_oe <= 1'b1;
    end
    else if (state_d == ST_IDLE)
      data_oe <= 1'b0;
  end

  // wait pin level and enable
  logic busy_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      wait_out <= 1'b0;
      wait_oe <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      wait_out <= hold_pol ? busy_d : !busy_d;
      wait_oe <= cfg_valid_q && (hold_drive || sel_win);
    end
  end

  // configuration outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_straps <= 16'h0000;
      alt_interface_sel <= 1'b0;
      port_active <= 1'b0;
    end
    else
    begin
      config_straps <= cfg_q;
      alt_interface_sel <= cfg_valid_q && cfg_q[`MPH_STRAP_ALT];
      port_active <= port_ok;
    end
  end

  // axi write side holding state
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic aw_hs, w_hs, wr_do, ar_hs;
  assign aw_hs = s_axil_awvalid && s_axil_awready;
  assign w_hs = s_axil_wvalid && s_axil_wready;
  assign wr_do = aw_got_q && w_got_q && !s_axil_bvalid;
  assign ar_hs = s_axil_arvalid && s_axil_arready;

  // address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (wr_do)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axil_awaddr;
      end
      if (w_hs)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
    end
  end

  // ready flags drop on capture, rise when slot free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
    end
    else
    begin
      s_axil_awready <= !aw_hs && !aw_got_q && !s_axil_awready ? !s_axil_bvalid : !aw_hs && !aw_got_q;
      s_axil_wready <= !w_hs && !w_got_q && !s_axil_wready ? !s_axil_bvalid : !w_hs && !w_got_q;
    end
  end

  // control register and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `MPH_CTRL_RESET;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `MPH_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= is_mapped(awaddr_q) ? `MPH_RESP_OKAY : `MPH_RESP_SLVERR;
      if (awaddr_q == `MPH_CTRL_OFS && wstrb_q[0])
        ctrl_q <= {24'h000000, 7'h00, wdata_q[0]};
    end
    else if (s_axil_bready)
      s_axil_bvalid <= 1'b0;
  end

  // read data select
  wire logic [31:0] rd_word;
  wire logic [31:0] status_word;
  assign status_word = {5'h00, upper_q, 12'h000, port_ok, cfg_valid_q, state_q};
  assign rd_word = !is_mapped(s_axil_araddr) ? 32'h00000000 :
                   s_axil_araddr[3:2] == `MPH_CTRL_OFS >> 2 ? ctrl_q :
                   s_axil_araddr[3:2] == `MPH_STRAPS_OFS >> 2 ? {16'h0000, cfg_q} :
                   s_axil_araddr[3:2] == `MPH_STATUS_OFS >> 2 ? status_word :
                   {8'h00, last_addr_q};

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= `MPH_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_word;
      s_axil_rresp <= is_mapped(s_axil_araddr) ? `MPH_RESP_OKAY : `MPH_RESP_SLVERR;
    end
    else
    begin
      if (s_axil_rready)
        s_axil_rvalid <= 1'b0;
      if (!s_axil_rvalid)
        s_axil_arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_start;
    state_q == ST_IDLE && start;
  endsequence
  sequence seq_req_wait;
    state_q == ST_REQ && !mem_ack;
  endsequence

  property p_sync;
    s_bus == $past(raw_bus, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin not seen two cycles later");
  property p_upper_latch;
    ale_fall |=> upper_q == $past(s_addr[10:0]);
  endproperty
  a_upper_latch: assert property (p_upper_latch) else $error("upper latch missed");
  property p_strap_hold;
    cfg_valid_q |=> $stable(cfg_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed");
  property p_mode;
    state_q == ST_IDLE && !port_ok |=> state_q == ST_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("access without port mode");
  property p_read_issue;
    seq_start ##0 rd_req |=> mem_req && !mem_write ##1 state_q == ST_REQ || state_q == ST_ALIGN;
  endproperty
  a_read_issue: assert property (p_read_issue) else $error("read not issued");
  property p_write_issue;
    seq_start ##0 (wr_req && !rd_req) |=> mem_req && mem_write;
  endproperty
  a_write_issue: assert property (p_write_issue) else $error("write not issued");
  property p_req_hold;
    seq_req_wait |=> mem_req && busy_q;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_wait_pol;
    state_q == ST_REQ |-> wait_out == hold_pol;
  endproperty
  a_wait_pol: assert property (p_wait_pol) else $error("wait level wrong");
  property p_wait_release;
    state_q == ST_DONE && $past(state_q) == ST_DONE |-> wait_out == !hold_pol;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released");
  property p_wait_drive;
    cfg_valid_q && hold_drive |=> wait_oe;
  endproperty
  a_wait_drive: assert property (p_wait_drive) else $error("wait not driven");
  property p_wait_float;
    cfg_valid_q && !hold_drive && !sel_win |=> !wait_oe;
  endproperty
  a_wait_float: assert property (p_wait_float) else $error("wait not floated");
  property p_region;
    $rose(mem_req) |-> mem_addr == $past(full_addr[20:0])
      && (mem_region == REGION_BUF) == $past(full_addr[23]);
  endproperty
  a_region: assert property (p_region) else $error("region decode wrong");
endmodule
`default_nettype wire

// *** mph_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// slot bus controller of the host processor
module mph_host_model
(
  input wire logic aclk,
  output logic host_port_clock,
  output logic upper_addr_strobe_in,
  output logic card_space_n,
  output logic io_read_strobe_in,
  output logic io_write_strobe_in,
  output logic read_strobe_n,
  output logic write_strobe_low_n,
  output logic byte_en_high_n,
  output logic byte_en_low_n,
  output logic [12:0] addr_in,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic wait_out,
  input wire logic wait_oe
);
  logic oe_seen; // wait enable while held
  logic doe_seen; // data enable at cycle end
  // bus clock runs free, unrelated to aclk
  initial
  begin
    host_port_clock = 1'b0;
    // 2.5 ns offset keeps its edges off every aclk edge
    #2.5;
    forever #17 host_port_clock = ~host_port_clock;
  end
  // idle pins
  initial
  begin
    {upper_addr_strobe_in, card_space_n} = 2'b01;
    {io_read_strobe_in, io_write_strobe_in, read_strobe_n, write_strobe_low_n} = 4'hF;
    {byte_en_high_n, byte_en_low_n} = 2'b11;
    addr_in = 13'h0000;
    data_in = 16'h0000;
  end
  // one slot cycle: upper bits on the strobe, then low bits and command
  task automatic access(input logic wr, input logic io, input logic [10:0] up, input logic [12:0] lo,
    input logic [1:0] ben, input logic [15:0] wd, input logic pol, output logic [15:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge aclk);
    addr_in <= {2'h0, up};
    upper_addr_strobe_in <= 1'b1;
    repeat (4) @(posedge aclk);
    upper_addr_strobe_in <= 1'b0;
    repeat (4) @(posedge aclk);
    addr_in <= lo;
    {byte_en_high_n, byte_en_low_n} <= ~ben;
    // slot select reaches only this device, other cards stay quiet
    card_space_n <= 1'b0;
    data_in <= wr ? wd : ~data_in;
    io_write_strobe_in <= !(wr && io);
    write_strobe_low_n <= !(wr && !io);
    io_read_strobe_in <= !(!wr && io);
    read_strobe_n <= !(!wr && !io);
    // give up if the port never holds the cycle
    while (n < 20 && !ok)
    begin
      @(posedge aclk);
      // a floating wait line never holds the cycle
      ok = wait_oe && (wait_out === pol);
      n++;
    end
    oe_seen = wait_oe;
    // stretch the cycle while held
    while (ok && wait_oe && wait_out === pol)
      @(posedge aclk);
    rd = data_out;
    doe_seen = data_oe;
    {io_read_strobe_in, io_write_strobe_in, read_strobe_n, write_strobe_low_n} <= 4'hF;
    card_space_n <= 1'b1;
    // released lines show a changed pattern
    addr_in <= ~lo;
    data_in <= ~data_in;
    repeat (4) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mph_regs.svh"
// self checking bench for the slot port
module tb;
  import mph_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0; // sync reset
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic [31:0] s_axil_wdata = 32'h00000000, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic host_port_clock, upper_addr_strobe_in, card_space_n, io_read_strobe_in, io_write_strobe_in;
  logic read_strobe_n, write_strobe_low_n, byte_en_high_n, byte_en_low_n;
  logic [12:0] addr_in;
  logic [15:0] data_in, data_out, config_straps, mem_wdata;
  logic [15:0] config_straps_in = 16'h0000;
  logic data_oe, wait_out, wait_oe, alt_interface_sel, port_active, mem_req, mem_write;
  mph_region_type mem_region, cap_reg;
  logic [20:0] mem_addr, cap_addr;
  logic [1:0] mem_byte_en, cap_be;
  logic mem_ack = 1'b0;
  logic [15:0] mem_rdata = 16'h0000, rdat = 16'h0000, cap_wd, hrd;
  logic cap_wr, hok;
  logic [31:0] rv;
  logic [1:0] rr;
  int ack_dly = 0; // memory side stall
  int ack_cnt = 0;
  int req_cnt = 0; // requests answered
  int error_cnt = 0;
  int n_tests = 0;
  mph_port dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .host_port_clock,
    .upper_addr_strobe_in, .card_space_n, .io_read_strobe_in, .io_write_strobe_in, .read_strobe_n,
    .write_strobe_low_n, .byte_en_high_n, .byte_en_low_n, .addr_in, .data_in, .data_out, .data_oe, .wait_out,
    .wait_oe, .config_straps_in, .config_straps, .alt_interface_sel, .port_active, .mem_req, .mem_write,
    .mem_region, .mem_addr, .mem_wdata, .mem_byte_en, .mem_ack, .mem_rdata);
  mph_host_model host (.aclk, .host_port_clock, .upper_addr_strobe_in, .card_space_n, .io_read_strobe_in,
    .io_write_strobe_in, .read_strobe_n, .write_strobe_low_n, .byte_en_high_n, .byte_en_low_n, .addr_in,
    .data_in, .data_out, .data_oe, .wait_out, .wait_oe);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // memory side answers each request after a stall
  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~rdat;
    if (mem_req && !mem_ack)
    begin
      if (ack_cnt >= ack_dly)
      begin
        mem_ack <= 1'b1;
        mem_rdata <= rdat;
        ack_cnt <= 0;
        req_cnt <= req_cnt + 1;
        cap_wr <= mem_write;
        cap_reg <= mem_region;
        cap_addr <= mem_addr;
        cap_wd <= mem_wdata;
        cap_be <= mem_byte_en;
      end
      else
        ack_cnt <= ack_cnt + 1;
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // reset with a strap set applied well before release
  task automatic do_reset(input logic [15:0] st);
    @(posedge aclk);
    aresetn <= 1'b0;
    config_straps_in <= st;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  // register write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'b111;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok || s_axil_awready;
      w_ok = w_ok || s_axil_wready;
      s_axil_awvalid <= !aw_ok;
      s_axil_wvalid <= !w_ok;
    end
    do @(posedge aclk); while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  // register read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
  // verdict and end of run
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial
  begin
    do_reset(16'h883E);
    chk("straps", config_straps, 16'h883E);
    chk("alt", alt_interface_sel, 1'b1);
    chk("active", port_active, 1'b1);
    chk("wait oe idle", wait_oe, 1'b1);
    chk("wait idle", wait_out, 1'b0);
    config_straps_in <= 16'h0000;
    repeat (4) @(posedge aclk);
    chk("straps held", config_straps, 16'h883E);
    axi_rd(`MPH_CTRL_OFS, rv, rr);
    chk("ctrl", rv, `MPH_CTRL_RESET);
    axi_wr(`MPH_STRAPS_OFS, 32'h0000FFFF, rr);
    axi_rd(`MPH_STRAPS_OFS, rv, rr);
    chk("straps reg", rv, 32'h0000883E);
    axi_rd(8'h40, rv, rr);
    chk("unmapped", rr, `MPH_RESP_SLVERR);
    // io write into aliased register space, little endian, high byte only
    host.access(1'b1, 1'b1, 11'h2A5, 13'h1234, 2'b10, 16'hBEEF, 1'b1, hrd, hok);
    chk("wr taken", hok, 1'b1);
    chk("wr dir", cap_wr, 1'b1);
    chk("wr region", cap_reg, REGION_REG);
    chk("wr addr", cap_addr, {8'hA5, 13'h1234});
    chk("wr data", cap_wd, 16'hBEEF);
    chk("wr be", cap_be, 2'b10);
    // general read of buffer space with a slow memory
    ack_dly = 7;
    rdat = 16'h1357;
    host.access(1'b0, 1'b0, 11'h4C3, 13'h0FFE, 2'b11, 16'h0000, 1'b1, hrd, hok);
    chk("rd data", hrd, 16'h1357);
    chk("rd oe", host.doe_seen, 1'b1);
    chk("rd region", cap_reg, REGION_BUF);
    chk("rd addr", cap_addr, {8'hC3, 13'h0FFE});
    axi_rd(`MPH_ADDR_OFS, rv, rr);
    chk("last addr", rv, {8'h00, 11'h4C3, 13'h0FFE});
    // port disabled by software
    axi_wr(`MPH_CTRL_OFS, 32'h00000000, rr);
    chk("wr resp", rr, `MPH_RESP_OKAY);
    host.access(1'b1, 1'b1, 11'h001, 13'h0002, 2'b11, 16'h5555, 1'b1, hrd, hok);
    chk("off refused", req_cnt, 2);
    axi_wr(`MPH_CTRL_OFS, 32'h00000001, rr);
    // big endian, low wait level, wait floats when idle, halved host clock
    do_reset(16'h180E);
    chk("wait oe float", wait_oe, 1'b0);
    chk("wait idle lo", wait_out, 1'b1);
    ack_dly = 2;
    rdat = 16'hC0DE;
    host.access(1'b1, 1'b0, 11'h2F0, 13'h1FFF, 2'b11, 16'h12AB, 1'b0, hrd, hok);
    chk("be taken", hok, 1'b1);
    chk("be oe", host.oe_seen, 1'b1);
    chk("be wdata", cap_wd, 16'hAB12);
    host.access(1'b0, 1'b1, 11'h7FF, 13'h0000, 2'b11, 16'h0000, 1'b0, hrd, hok);
    chk("be rdata", hrd, 16'hDEC0);
    chk("be addr", cap_addr, {8'hFF, 13'h0000});
    // wrong mode straps: port stays silent
    for (int i = 0; i < 2; i++)
    begin
      do_reset(i == 0 ? 16'h800E : 16'h080C);
      chk("inactive", port_active, 1'b0);
      chk("alt set", alt_interface_sel, i[0]);
      host.access(1'b0, 1'b1, 11'h010, 13'h0010, 2'b11, 16'h0000, 1'b0, hrd, hok);
      chk("no req", req_cnt, 4);
    end
    print_verdict;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
